// File: hw/sgoc_defines.vh
// constants for the switchgear object control block
// assumes a 125 MHz system clock and a 1 ms tick derived inside
`ifndef SGOC_DEFINES_VH
`define SGOC_DEFINES_VH
`define SGOC_CLK_HZ        125000000
`define SGOC_TICK_MS       1
`define SGOC_TICK_CYC      ((`SGOC_CLK_HZ / 1000) * `SGOC_TICK_MS)
`define SGOC_TICK_W        17
`define SGOC_TMO_W         20
`define SGOC_TMO_MIN_MS    20'h0_0014
`define SGOC_TMO_MAX_MS    20'h9_27C0
`define SGOC_N_CTRL        6
`define SGOC_N_OBJ         8
`define SGOC_N_DI          20
`define SGOC_N_VI          4
`define SGOC_N_VO          6
`define SGOC_N_SRC         31
`define SGOC_SEL_W         5
`define SGOC_SEL_NONE      5'h00
`define SGOC_N_OUT         16
`define SGOC_N_STAGE       8
`define SGOC_N_BSRC        32
`define SGOC_ST_UNDEF00    2'h0
`define SGOC_ST_OPEN       2'h1
`define SGOC_ST_CLOSED     2'h2
`define SGOC_ST_UNDEF11    2'h3
`endif

// File: hw/sgoc_top.v
// switchgear object control: commands, supervision, output and block matrix
// assumes pins are raw asynchronous; panel/bus/config are on sys_clk_i
`timescale 1ns/1ps
`include "sgoc_defines.vh"

module sgoc_top
(
  // clock and reset
  input  wire                                 sys_clk_i,
  input  wire                                 nrst_i,
  // physical digital inputs (asynchronous)
  input  wire [`SGOC_N_DI-1:0]                di_pin_i,
  // soft inputs written by panel, bus or setup tool
  input  wire [`SGOC_N_VI-1:0]                soft_input_i,
  // status source selection, 5 bits per object
  input  wire [`SGOC_N_OBJ*`SGOC_SEL_W-1:0]   open_status_source_i,
  input  wire [`SGOC_N_OBJ*`SGOC_SEL_W-1:0]   closed_status_source_i,
  input  wire [`SGOC_N_CTRL*`SGOC_SEL_W-1:0]  ready_status_source_i,
  // timeouts in ms per object
  input  wire [`SGOC_N_OBJ*`SGOC_TMO_W-1:0]   max_pulse_ms_i,
  input  wire [`SGOC_N_CTRL*`SGOC_TMO_W-1:0]  completion_ms_i,
  // panel and bus commands (one-cycle pulses)
  input  wire [`SGOC_N_CTRL-1:0]              panel_select_i,
  input  wire [`SGOC_N_CTRL-1:0]              panel_exec_i,
  input  wire [`SGOC_N_CTRL-1:0]              panel_cancel_i,
  input  wire [`SGOC_N_CTRL-1:0]              panel_dir_close_i,
  input  wire [`SGOC_N_CTRL-1:0]              bus_select_i,
  input  wire [`SGOC_N_CTRL-1:0]              bus_exec_i,
  input  wire [`SGOC_N_CTRL-1:0]              bus_cancel_i,
  input  wire [`SGOC_N_CTRL-1:0]              bus_dir_close_i,
  input  wire [`SGOC_N_CTRL-1:0]              ar_open_i,
  input  wire [`SGOC_N_CTRL-1:0]              ar_close_i,
  // input control selection per object
  input  wire [`SGOC_N_CTRL*`SGOC_SEL_W-1:0]  rem_open_src_i,
  input  wire [`SGOC_N_CTRL*`SGOC_SEL_W-1:0]  rem_close_src_i,
  input  wire [`SGOC_N_CTRL*`SGOC_SEL_W-1:0]  loc_open_src_i,
  input  wire [`SGOC_N_CTRL*`SGOC_SEL_W-1:0]  loc_close_src_i,
  // local/remote mode
  input  wire                                 panel_remote_i,
  input  wire [`SGOC_SEL_W-1:0]               lr_src_i,
  // output matrix
  input  wire [`SGOC_N_OUT*`SGOC_N_BSRC-1:0]  out_map_i,
  input  wire [`SGOC_N_OUT-1:0]               out_latch_i,
  input  wire [`SGOC_SEL_W-1:0]               release_src_i,
  input  wire                                 release_cmd_i,
  input  wire [`SGOC_N_VO*`SGOC_N_BSRC-1:0]   vo_map_i,
  // blocking matrix
  input  wire [`SGOC_N_STAGE-1:0]             stage_start_i,
  input  wire [`SGOC_N_STAGE-1:0]             stage_trip_i,
  input  wire [`SGOC_N_STAGE*`SGOC_N_BSRC-1:0] block_map_i,
  // object state and commands
  output reg  [`SGOC_N_OBJ*2-1:0]             obj_state_o,
  output reg  [`SGOC_N_CTRL-1:0]              obj_open_cmd_o,
  output reg  [`SGOC_N_CTRL-1:0]              obj_close_cmd_o,
  output reg  [`SGOC_N_OBJ-1:0]               obj_fail_o,
  output reg                                  obj_fail_any_o,
  output reg  [`SGOC_N_OBJ-1:0]               undef_event_o,
  // mode, matrices
  output reg                                  remote_mode_o,
  output reg  [`SGOC_N_OUT-1:0]               out_o,
  output reg  [`SGOC_N_VO-1:0]                virt_out_o,
  output reg  [`SGOC_N_STAGE-1:0]             stage_block_o
);

  // state machine of a controllable object
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_SEL   = 4'b0010;
  localparam [3:0] S_PULSE = 4'b0100;
  localparam [3:0] S_READY = 4'b1000;
  // field widths of the packed per-object settings and matrix maps
  localparam SW = `SGOC_SEL_W;
  localparam TW = `SGOC_TMO_W;
  localparam BW = `SGOC_N_BSRC;

  // three-stage sync; change accepted when stages two and three agree
  reg [`SGOC_N_DI-1:0] di_s1_q, di_s2_q, di_s3_q, di_q;
  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      di_s1_q <= {`SGOC_N_DI{1'b0}};
      di_s2_q <= {`SGOC_N_DI{1'b0}};
      di_s3_q <= {`SGOC_N_DI{1'b0}};
      di_q    <= {`SGOC_N_DI{1'b0}};
    end
    else
    begin
      di_s1_q <= di_pin_i;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
      di_q    <= (di_s2_q & di_s3_q) | (di_q & (di_s2_q | di_s3_q));
    end

  // ms tick
  reg [`SGOC_TICK_W-1:0] tick_cnt_q;
  reg                    tick_q;
  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      tick_cnt_q <= {`SGOC_TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == `SGOC_TICK_CYC - 1);
      if (tick_cnt_q == `SGOC_TICK_CYC - 1)
        tick_cnt_q <= {`SGOC_TICK_W{1'b0}};
      else
        tick_cnt_q <= tick_cnt_q + 1'b1;
    end

  // source vector: index 0 none, 1..20 DI, 21..24 soft, 25..30 VO
  wire [`SGOC_N_SRC:0] src = {1'b0, virt_out_o, soft_input_i,
                              di_q, 1'b0};

  // mode: input overrides panel when one is chosen
  wire remote_d = (lr_src_i == `SGOC_SEL_NONE) ? panel_remote_i
                                               : src[lr_src_i];

  // latched release from any selected input or command
  wire release_w = release_cmd_i |
                   ((release_src_i != `SGOC_SEL_NONE) & src[release_src_i]);

  // combined signal pool for matrices
  wire [`SGOC_N_BSRC-1:0] pool = {stage_trip_i, stage_start_i,
                                  obj_fail_o[`SGOC_N_CTRL-1:0],
                                  virt_out_o, di_q[3:0]};

  genvar g;
  generate
    for (g = 0; g < `SGOC_N_OBJ; g = g + 1)
    begin : g_obj
      wire       op_w = src[open_status_source_i[g*SW +: SW]];
      wire       cl_w = src[closed_status_source_i[g*SW +: SW]];
      wire [1:0] st_w = {cl_w, op_w} == 2'b00 ? `SGOC_ST_UNDEF00 :
                        {cl_w, op_w} == 2'b01 ? `SGOC_ST_OPEN :
                        {cl_w, op_w} == 2'b10 ? `SGOC_ST_CLOSED :
                                                `SGOC_ST_UNDEF11;
      wire [`SGOC_TMO_W-1:0] lim_w = max_pulse_ms_i[g*TW +: TW];
      reg  [`SGOC_TMO_W-1:0] tmr_q;
      reg  [1:0]             prev_q;
      reg                    trans_q;
      always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
          prev_q <= `SGOC_ST_UNDEF00;
        else
          prev_q <= st_w;
      always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
          obj_state_o[g*2 +: 2] <= `SGOC_ST_UNDEF00;
        else
          obj_state_o[g*2 +: 2] <= st_w;
      if (g >= `SGOC_N_CTRL)
      begin : g_ro
        // status-only: supervise time spent in an intermediate state
        always @(posedge sys_clk_i or negedge nrst_i)
          if (!nrst_i)
          begin
            tmr_q            <= {`SGOC_TMO_W{1'b0}};
            trans_q          <= 1'b0;
            obj_fail_o[g]    <= 1'b0;
            undef_event_o[g] <= 1'b0;
          end
          else
          begin
            undef_event_o[g] <= 1'b0;
            if (st_w == `SGOC_ST_OPEN || st_w == `SGOC_ST_CLOSED)
            begin
              trans_q       <= 1'b0;
              tmr_q         <= {`SGOC_TMO_W{1'b0}};
              obj_fail_o[g] <= 1'b0;
            end
            else if (trans_q | (st_w != prev_q))
            begin
              trans_q <= 1'b1;
              if (tick_q && trans_q)
                tmr_q <= tmr_q + 1'b1;
              if (trans_q && tmr_q >= lim_w)
              begin
                trans_q          <= 1'b0;
                obj_fail_o[g]    <= 1'b1;
                undef_event_o[g] <= 1'b1;
              end
            end
          end
      end
      else
      begin : g_ctl
        wire [`SGOC_TMO_W-1:0] rdy_lim = completion_ms_i[g*TW +: TW];
        wire rsel = ready_status_source_i[g*SW +: SW] != `SGOC_SEL_NONE;
        wire rdy  = src[ready_status_source_i[g*SW +: SW]];
        wire ro_w = src[rem_open_src_i[g*SW +: SW]];
        wire rc_w = src[rem_close_src_i[g*SW +: SW]];
        wire lo_w = src[loc_open_src_i[g*SW +: SW]];
        wire lc_w = src[loc_close_src_i[g*SW +: SW]];
        reg  [3:0] in_q;
        reg  [3:0] fsm_q;
        reg        dir_q;
        // edge only; 60 ms input pulse assumed from the source
        wire [3:0] rise = {ro_w, rc_w, lo_w, lc_w} & ~in_q;
        wire di_op = remote_mode_o ? rise[3] : rise[1];
        wire di_cl = remote_mode_o ? rise[2] : rise[0];
        // panel only in local, bus only in remote; no password check
        wire sel  = remote_mode_o ? bus_select_i[g] : panel_select_i[g];
        wire exe  = remote_mode_o ? bus_exec_i[g]   : panel_exec_i[g];
        wire can  = remote_mode_o ? bus_cancel_i[g] : panel_cancel_i[g];
        wire dcl  = remote_mode_o ? bus_dir_close_i[g]
                                  : panel_dir_close_i[g];
        wire go_op = di_op | ar_open_i[g];
        wire go_cl = di_cl | ar_close_i[g];
        wire reached = dir_q ? (st_w == `SGOC_ST_CLOSED)
                             : (st_w == `SGOC_ST_OPEN);
        always @(posedge sys_clk_i or negedge nrst_i)
          if (!nrst_i)
          begin
            in_q               <= 4'h0;
            fsm_q              <= S_IDLE;
            dir_q              <= 1'b0;
            tmr_q              <= {`SGOC_TMO_W{1'b0}};
            trans_q            <= 1'b0;
            obj_fail_o[g]      <= 1'b0;
            undef_event_o[g]   <= 1'b0;
            obj_open_cmd_o[g]  <= 1'b0;
            obj_close_cmd_o[g] <= 1'b0;
          end
          else
          begin
            in_q             <= {ro_w, rc_w, lo_w, lc_w};
            undef_event_o[g] <= 1'b0;
            trans_q          <= 1'b0;
            if (tick_q)
              tmr_q <= tmr_q + 1'b1;
            case (fsm_q)
              S_IDLE:
                if (go_op | go_cl | exe)
                begin
                  dir_q         <= go_cl | (exe & dcl & ~go_op);
                  tmr_q         <= {`SGOC_TMO_W{1'b0}};
                  obj_fail_o[g] <= 1'b0;
                  fsm_q         <= S_PULSE;
                end
                else if (sel)
                begin
                  dir_q <= dcl;
                  fsm_q <= S_SEL;
                end
              S_SEL:
                if (can)
                  fsm_q <= S_IDLE;
                else if (exe)
                begin
                  tmr_q         <= {`SGOC_TMO_W{1'b0}};
                  obj_fail_o[g] <= 1'b0;
                  fsm_q         <= S_PULSE;
                end
              S_PULSE:
                if (reached)
                begin
                  tmr_q <= {`SGOC_TMO_W{1'b0}};
                  fsm_q <= rsel ? S_READY : S_IDLE;
                end
                else if (tmr_q >= lim_w)
                begin
                  obj_fail_o[g]    <= 1'b1;
                  undef_event_o[g] <= 1'b1;
                  fsm_q            <= S_IDLE;
                end
              S_READY:
                if (rdy)
                  fsm_q <= S_IDLE;
                else if (tmr_q >= rdy_lim)
                begin
                  obj_fail_o[g] <= 1'b1;
                  fsm_q         <= S_IDLE;
                end
              default:
                fsm_q <= S_IDLE;
            endcase
            // pulse held at most the set length
            obj_open_cmd_o[g]  <= (fsm_q == S_PULSE) & ~dir_q &
                                  ~reached & (tmr_q < lim_w);
            obj_close_cmd_o[g] <= (fsm_q == S_PULSE) & dir_q &
                                  ~reached & (tmr_q < lim_w);
          end
      end
    end

    // output matrix with per-output latch
    for (g = 0; g < `SGOC_N_OUT; g = g + 1)
    begin : g_out
      wire hit = |(out_map_i[g*BW +: BW] & pool);
      always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
          out_o[g] <= 1'b0;
        else if (out_latch_i[g])
          out_o[g] <= hit | (out_o[g] & ~release_w);
        else
          out_o[g] <= hit;
    end

    // virtual outputs, fed back as sources one cycle later
    for (g = 0; g < `SGOC_N_VO; g = g + 1)
    begin : g_vo
      always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
          virt_out_o[g] <= 1'b0;
        else
          virt_out_o[g] <= |(vo_map_i[g*BW +: BW] & pool);
    end

    // blocking matrix
    for (g = 0; g < `SGOC_N_STAGE; g = g + 1)
    begin : g_blk
      always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
          stage_block_o[g] <= 1'b0;
        else
          stage_block_o[g] <= |(block_map_i[g*BW +: BW] & pool);
    end
  endgenerate

  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      remote_mode_o  <= 1'b0;
      obj_fail_any_o <= 1'b0;
    end
    else
    begin
      remote_mode_o  <= remote_d;
      obj_fail_any_o <= |obj_fail_o;
    end

endmodule // sgoc_top

// File: testbench/sgoc_top_properties.sv
// property checker for the switchgear object control block
// assumes object 1 status on DI1/DI2, ready unused, release source none
`timescale 1ns/1ps
module sgoc_chk
(
  // clock and reset
  input wire         sys_clk_i,
  input wire         nrst_i,
  // inputs
  input wire [19:0]  di_pin_i,
  input wire [39:0]  open_status_source_i,
  input wire [39:0]  closed_status_source_i,
  input wire [5:0]   panel_exec_i,
  input wire [5:0]   panel_dir_close_i,
  input wire [5:0]   bus_exec_i,
  input wire [5:0]   bus_dir_close_i,
  input wire [5:0]   ar_open_i,
  input wire         release_cmd_i,
  input wire [15:0]  out_latch_i,
  input wire [7:0]   stage_trip_i,
  input wire [255:0] block_map_i,
  // outputs
  input wire [15:0]  obj_state_o,
  input wire [5:0]   obj_open_cmd_o,
  input wire [5:0]   obj_close_cmd_o,
  input wire [7:0]   obj_fail_o,
  input wire         obj_fail_any_o,
  input wire [7:0]   undef_event_o,
  input wire         remote_mode_o,
  input wire [15:0]  out_o,
  input wire [7:0]   stage_block_o
);
  // quiet pins rule out input-driven commands in the source check
  reg  [19:0] di_q;
  reg  [3:0]  quiet_q;
  reg  [7:0]  ev_q;
  wire        pan = panel_exec_i[0] & ~panel_dir_close_i[0];
  wire        bus = bus_exec_i[0] & ~bus_dir_close_i[0];
  wire        ok_open = ar_open_i[0] | (remote_mode_o ? bus : pan);
  wire        idle0 = ~obj_open_cmd_o[0] & ~obj_close_cmd_o[0];
  wire        src_ok = open_status_source_i[4:0] == 5'h01 &&
                       closed_status_source_i[4:0] == 5'h02;
  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      di_q    <= 20'h0_0000;
      quiet_q <= 4'h0;
      ev_q    <= 8'h00;
    end
    else
    begin
      di_q    <= di_pin_i;
      ev_q    <= undef_event_o;
      quiet_q <= (di_pin_i != di_q) ? 4'h0 :
                 quiet_q + {3'h0, quiet_q != 4'hf};
    end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_state_decode: assert property (
    (src_ok && $stable(di_pin_i[1:0]))[*8] |->
    obj_state_o[1:0] == {di_pin_i[1], di_pin_i[0]})
    else $error("object state differs from contacts");
  chk_cmd_source: assert property (
    $rose(obj_open_cmd_o[0]) && quiet_q == 4'hf |-> $past(ok_open, 2))
    else $error("open pulse without an accepted request");
  chk_exec_answer: assert property (
    idle0[*3] ##0 (pan && !remote_mode_o && quiet_q == 4'hf &&
    obj_state_o[1:0] == 2'h2) |-> ##2 obj_open_cmd_o[0])
    else $error("direct open not answered");
  chk_early_end: assert property (
    obj_open_cmd_o[0] && obj_state_o[1:0] == 2'h1 |->
    ##[1:3] !obj_open_cmd_o[0])
    else $error("open pulse runs on after position");
  chk_fail_event: assert property (
    $rose(obj_fail_o[0]) |-> ##[0:1] (undef_event_o[0] || ev_q[0]))
    else $error("failure without undefined event");
  chk_fail_any: assert property (
    obj_fail_o[5:0] != 6'h00 |-> ##[0:1] obj_fail_any_o)
    else $error("common failure flag missing");
  chk_block_map: assert property (
    (block_map_i[23:0] == 24'h00_0000 && $stable(stage_trip_i))[*3] |->
    stage_block_o[0] == |(block_map_i[31:24] & stage_trip_i))
    else $error("stage block does not follow trip mask");
  chk_latch_hold: assert property (
    out_latch_i[1] && out_o[1] && !release_cmd_i |=> out_o[1])
    else $error("latched output dropped without release");
endmodule // sgoc_chk
bind sgoc_top sgoc_chk u_chk (.*);

// File: testbench/sgoc_switch_model.sv
// breaker model for object 1: travels after an accepted pulse
// assumes level pulses from the block, contacts wired to DI1/DI2
`timescale 1ns/1ps
module sgoc_switch_model
#(
  parameter TRAVEL = 20
)
(
  // clock and commands
  input  wire sys_clk_i,
  input  wire open_cmd_i,
  input  wire close_cmd_i,
  // contacts
  output reg  open_o = 1'b0,
  output reg  closed_o = 1'b1
);
  reg [7:0] cnt_q = 8'h00;
  reg       tgt_q = 1'b1;
  // mid travel both contacts are open, giving undefined 00
  always @(posedge sys_clk_i)
    if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01)
      begin
        open_o   <= !tgt_q;
        closed_o <= tgt_q;
      end
    end
    else if ((open_cmd_i && closed_o) || (close_cmd_i && open_o))
    begin
      tgt_q    <= close_cmd_i;
      cnt_q    <= TRAVEL[7:0];
      open_o   <= 1'b0;
      closed_o <= 1'b0;
    end
endmodule // sgoc_switch_model

// File: testbench/tb_top.sv
// self-checking bench for the switchgear object control block
// assumes the breaker model on DI1/DI2; ms timeouts too long to run
`timescale 1ns/1ps
module tb_top;
  logic         sys_clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic [19:0]  di_tb = 20'h0_0000;
  wire  [19:0]  di_pin_i;
  wire          m_open, m_closed;
  logic [3:0]   soft_input_i;
  logic [39:0]  open_status_source_i, closed_status_source_i;
  logic [29:0]  ready_status_source_i, rem_open_src_i, rem_close_src_i;
  logic [29:0]  loc_open_src_i, loc_close_src_i;
  logic [159:0] max_pulse_ms_i;
  logic [119:0] completion_ms_i;
  logic [5:0]   panel_select_i, panel_exec_i, panel_cancel_i;
  logic [5:0]   panel_dir_close_i, bus_select_i, bus_exec_i, bus_cancel_i;
  logic [5:0]   bus_dir_close_i, ar_open_i, ar_close_i;
  logic         panel_remote_i, release_cmd_i, hold;
  logic [4:0]   lr_src_i, release_src_i;
  logic [511:0] out_map_i;
  logic [15:0]  out_latch_i;
  logic [191:0] vo_map_i;
  logic [7:0]   stage_start_i, stage_trip_i;
  logic [255:0] block_map_i;
  wire  [15:0]  obj_state_o, out_o;
  wire  [5:0]   obj_open_cmd_o, obj_close_cmd_o, virt_out_o;
  wire  [7:0]   obj_fail_o, undef_event_o, stage_block_o;
  wire          obj_fail_any_o, remote_mode_o;
  int           err_count = 0, check_count = 0, lat;
  logic [31:0]  r;

  assign di_pin_i = {di_tb[19:2], m_closed, m_open};
  always #4 sys_clk_i = ~sys_clk_i;
  sgoc_top dut (.*);
  sgoc_switch_model #(.TRAVEL(20)) u_sw (
    .sys_clk_i   (sys_clk_i),
    .open_cmd_i  (obj_open_cmd_o[0]),
    .close_cmd_i (obj_close_cmd_o[0]),
    .open_o      (m_open),
    .closed_o    (m_closed));

  task stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // one-cycle request; m picks panel exec, bus exec, bus select
  task cmd(input logic [2:0] m, input logic cls);
    @(negedge sys_clk_i);
    {panel_exec_i[0], bus_exec_i[0], bus_select_i[0]} = m;
    panel_dir_close_i[0] = cls;
    bus_dir_close_i[0] = cls;
    @(negedge sys_clk_i);
    {panel_exec_i[0], bus_exec_i[0], bus_select_i[0]} = 3'b000;
  endtask
  task wait_pos(input logic [1:0] p);
    lat = 0;
    while (obj_state_o[1:0] !== p && lat < 2000)
    begin
      tick(1);
      lat++;
    end
    if (lat == 2000)
    begin
      err_count++;
      $display("BAD %0t object never settled", $time);
      stop_test;
    end
  endtask
  task drv_neg;
    @(negedge sys_clk_i);
  endtask

  initial
  begin
    {soft_input_i, ready_status_source_i, rem_close_src_i} = '0;
    {loc_close_src_i, panel_select_i, panel_exec_i, panel_cancel_i} = '0;
    {panel_dir_close_i, bus_select_i, bus_exec_i, bus_cancel_i} = '0;
    {bus_dir_close_i, ar_open_i, ar_close_i, panel_remote_i} = '0;
    {release_cmd_i, lr_src_i, release_src_i, hold} = '0;
    {stage_start_i, stage_trip_i, out_map_i, vo_map_i, block_map_i} = '0;
    open_status_source_i = {5'h00, 5'h15, 30'h0000_0001};
    closed_status_source_i = {5'h00, 5'h16, 30'h0000_0002};
    rem_open_src_i = 30'h0000_0004;
    loc_open_src_i = 30'h0000_0005;
    max_pulse_ms_i = {8{20'h0_1388}};
    completion_ms_i = {6{20'h0_0014}};
    out_map_i[63:0] = {2{32'h00FF_0000}};
    out_latch_i = 16'h0002;
    vo_map_i[31:0] = 32'h00FF_0000;
    block_map_i[31:0] = 32'hFF00_0000;
    r = $urandom(32'hcabf);
    repeat (20) @(negedge sys_clk_i);
    chk(out_o | {obj_open_cmd_o, obj_close_cmd_o}, 16'h0000);
    nrst_i = 1'b1;
    tick(12);
    chk(obj_state_o[1:0], 2'h2);
    cmd(3'b010, 1'b0);
    tick(6);
    chk(obj_open_cmd_o[0], 1'b0);
    cmd(3'b100, 1'b0);
    tick(2);
    chk(obj_open_cmd_o[0], 1'b1);
    tick(8);
    chk(obj_state_o[1:0], 2'h0);
    wait_pos(2'h1);
    tick(4);
    chk(obj_open_cmd_o[0], 1'b0);
    drv_neg;
    panel_remote_i = 1'b1;
    tick(4);
    cmd(3'b100, 1'b1);
    tick(6);
    chk(obj_close_cmd_o[0], 1'b0);
    cmd(3'b001, 1'b1);
    cmd(3'b010, 1'b1);
    tick(2);
    chk(obj_close_cmd_o[0], 1'b1);
    wait_pos(2'h2);
    drv_neg;
    panel_remote_i = 1'b0;
    lr_src_i = 5'h03;
    tick(10);
    chk(remote_mode_o, 1'b0);
    drv_neg;
    di_tb[2] = 1'b1;
    tick(10);
    chk(remote_mode_o, 1'b1);
    drv_neg;
    di_tb[4] = 1'b1;
    tick(40);
    chk(obj_state_o[1:0], 2'h2);
    drv_neg;
    di_tb[3] = 1'b1;
    wait_pos(2'h1);
    drv_neg;
    ar_close_i[0] = 1'b1;
    drv_neg;
    ar_close_i[0] = 1'b0;
    wait_pos(2'h2);
    tick(60);
    chk(obj_state_o[1:0], 2'h2);
    drv_neg;
    di_tb[4:3] = 2'b00;
    repeat (8)
    begin
      r = $urandom;
      drv_neg;
      soft_input_i = r[3:0];
      tick(4);
      chk(obj_state_o[13:12], r[1:0]);
    end
    repeat (16)
    begin
      r = $urandom;
      drv_neg;
      stage_start_i = r[7:0] & {8{r[16]}};
      stage_trip_i = r[15:8] & {8{r[17]}};
      tick(4);
      hold = hold | (|stage_start_i);
      chk({out_o[1:0], virt_out_o[0], stage_block_o[0]}, {hold,
        |stage_start_i, |stage_start_i, |stage_trip_i});
    end
    drv_neg;
    stage_start_i = 8'h00;
    release_cmd_i = 1'b1;
    tick(4);
    chk(out_o[1], 1'b0);
    drv_neg;
    release_cmd_i = 1'b0;
    stop_test;
  end
endmodule // tb_top
